// ===== hdl/uls_pkg.sv
// shared constants and carrier types for the line status block
package uls_pkg;
   // ---------------------------------------------------------------
   // register map (word indices; byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0] ULS_LINE_STATUS_OFF = 8'h05;
   localparam logic [7:0] ULS_RX_DATA_OFF     = 8'h00;
   localparam logic [7:0] ULS_TX_DATA_OFF     = 8'h00;
   localparam logic [7:0] ULS_CONTROL_OFF     = 8'h08;
   localparam logic [7:0] ULS_LINE_STATUS_RST = 8'hc0;
   // byte addresses: one aligned 32-bit word per register index
   localparam logic [7:0] ULS_LINE_STATUS_ADDR =
      {ULS_LINE_STATUS_OFF[5:0], 2'b00};
   localparam logic [7:0] ULS_RX_DATA_ADDR =
      {ULS_RX_DATA_OFF[5:0], 2'b00};
   localparam logic [7:0] ULS_TX_DATA_ADDR =
      {ULS_TX_DATA_OFF[5:0], 2'b00};
   localparam logic [7:0] ULS_CONTROL_ADDR =
      {ULS_CONTROL_OFF[5:0], 2'b00};
   // line status fields
   localparam int ULS_B_DR   = 0;
   localparam int ULS_B_OE   = 1;
   localparam int ULS_B_PE   = 2;
   localparam int ULS_B_FE   = 3;
   localparam int ULS_B_BI   = 4;
   localparam int ULS_B_THRE = 5;
   localparam int ULS_B_TEMT = 6;
   localparam int ULS_B_ERRF = 7;
   // control register fields
   localparam int ULS_C_FIFO = 0;
   localparam int ULS_C_PEN  = 1;
   localparam int ULS_C_PSEL = 2;
   localparam int ULS_C_WLEN = 4;
   localparam int ULS_C_IRX  = 6;
   localparam int ULS_C_ITX  = 7;
   localparam logic [7:0] ULS_CONTROL_RST = 8'h03;
   // ---------------------------------------------------------------
   // timing and sizes
   // ---------------------------------------------------------------
   localparam int ULS_CLK_HZ    = 10_000_000;
   localparam int ULS_BAUD      = 115_200;
   localparam int ULS_BIT_CYC   = ULS_CLK_HZ / ULS_BAUD;
   localparam int ULS_FIFO_DEPTH = 16;
   localparam int ULS_FIFO_AW    = 4;
   // received character with its own error marks
   typedef struct packed {
      logic       brk;
      logic       frm;
      logic       par;
      logic [7:0] data;
   } uls_rxchar_t;
   typedef struct packed {
      logic       en;
      logic [1:0] sel;
      logic [1:0] wlen;
   } uls_frame_t;
endpackage

// ===== hdl/uls_rx.sv
// serial receiver: frames characters, checks parity/stop, detects break
`timescale 1ns/1ps
`default_nettype none
module uls_rx
   import uls_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         sys_rst,
   // line and framing
   input  wire logic         rxd_sync,
   input  wire uls_frame_t   frame,
   // assembled character
   output logic              char_vld,
   output uls_rxchar_t       char_q
);
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_SHIFT = 3'b010,
      RX_WAIT = 3'b100
   } uls_rxst_t;

   uls_rxst_t   st_q;
   logic [15:0] cyc_q;
   logic [3:0]  bit_q;
   logic [10:0] sh_q;
   logic [15:0] low_q;
   logic        brk_seen_q;
   logic [3:0]  nbits;
   logic [3:0]  ndata;
   logic        par_calc;
   logic        lastbit;
   logic [15:0] char_cyc;

   // data bits 5..8, parity sits after data and before stop
   always_comb begin
      ndata    = 4'd5 + {2'b00, frame.wlen};
      nbits    = ndata + {3'b000, frame.en} + 4'd1;
      char_cyc = 16'(ULS_BIT_CYC) * (16'd1 + {12'd0, nbits});
      lastbit  = (bit_q == nbits - 4'd1);
      par_calc = ^(sh_q[7:0] & (8'hff >> (4'd8 - ndata)));
   end

   // ---------------------------------------------------------------
   // framing
   // ---------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_q  <= RX_IDLE;
         cyc_q <= 16'h0000;
         bit_q <= 4'h0;
         sh_q  <= 11'h000;
      end else begin
         unique case (st_q)
            RX_IDLE: begin
               bit_q <= 4'h0;
               if (!rxd_sync) begin
                  st_q  <= RX_SHIFT;
                  cyc_q <= 16'(ULS_BIT_CYC + ULS_BIT_CYC / 2);
               end
            end
            RX_SHIFT: begin
               if (cyc_q == 16'h0000) begin
                  sh_q[bit_q] <= rxd_sync;
                  bit_q <= bit_q + 4'd1;
                  cyc_q <= 16'(ULS_BIT_CYC - 1);
                  if (lastbit)
                     st_q <= RX_WAIT;
               end else begin
                  cyc_q <= cyc_q - 16'd1;
               end
            end
            RX_WAIT: begin
               if (rxd_sync)
                  st_q <= RX_IDLE;
            end
            default: st_q <= RX_IDLE;
         endcase
      end
   end

   // break: line low longer than one full character time
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         low_q      <= 16'h0000;
         brk_seen_q <= 1'b0;
      end else if (rxd_sync) begin
         low_q      <= 16'h0000;
         brk_seen_q <= 1'b0;
      end else if (low_q <= char_cyc) begin
         low_q <= low_q + 16'd1;
      end else begin
         brk_seen_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // character out
   // ---------------------------------------------------------------
   logic stop_bit;
   logic par_bit;
   logic par_bad;
   always_comb begin
      stop_bit = rxd_sync;
      par_bit  = sh_q[ndata];
      unique case (frame.sel)
         2'b00:   par_bad = (par_calc ^ par_bit) != 1'b1;
         2'b01:   par_bad = (par_calc ^ par_bit) != 1'b0;
         2'b10:   par_bad = par_bit != 1'b1;
         default: par_bad = par_bit != 1'b0;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         char_vld <= 1'b0;
         char_q   <= '0;
      end else begin
         char_vld <= 1'b0;
         if (st_q == RX_SHIFT && cyc_q == 16'h0000 && lastbit) begin
            char_vld    <= 1'b1;
            char_q.data <= sh_q[7:0] & (8'hff >> (4'd8 - ndata));
            char_q.frm  <= !stop_bit;
            char_q.par  <= frame.en && par_bad;
            char_q.brk  <= 1'b0;
         end else if (st_q == RX_WAIT && brk_seen_q && !char_q.brk) begin
            char_vld    <= 1'b1;
            char_q.data <= 8'h00;
            char_q.brk  <= 1'b1;
            char_q.frm  <= 1'b1;
            char_q.par  <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/uls_tx.sv
// serial transmitter: shifts out one character, reports when idle
`timescale 1ns/1ps
`default_nettype none
module uls_tx
   import uls_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         sys_rst,
   // character in
   input  wire logic         load,
   input  wire logic [7:0]   data,
   input  wire uls_frame_t   frame,
   output logic              busy,
   // line
   output logic              txd
);
   logic [15:0] cyc_q;
   logic [3:0]  left_q;
   logic [10:0] sh_q;
   logic [3:0]  ndata;
   logic        par;
   logic [10:0] word;

   always_comb begin
      ndata = 4'd5 + {2'b00, frame.wlen};
      par   = ^(data & (8'hff >> (4'd8 - ndata)));
      unique case (frame.sel)
         2'b00:   par = !par;
         2'b01:   par = par;
         2'b10:   par = 1'b1;
         default: par = 1'b0;
      endcase
      word = 11'h7ff;
      for (int i = 0; i < 8; i++)
         if (4'(i) < ndata) word[i] = data[i];
      if (frame.en) word[ndata] = par;
   end

   assign busy = (left_q != 4'h0);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cyc_q  <= 16'h0000;
         left_q <= 4'h0;
         sh_q   <= 11'h7ff;
         txd    <= 1'b1;
      end else if (load && !busy) begin
         sh_q   <= word;
         txd    <= 1'b0;
         cyc_q  <= 16'(ULS_BIT_CYC - 1);
         left_q <= ndata + {3'b000, frame.en} + 4'd2;
      end else if (busy) begin
         if (cyc_q == 16'h0000) begin
            cyc_q  <= 16'(ULS_BIT_CYC - 1);
            left_q <= left_q - 4'd1;
            txd    <= (left_q == 4'd1) ? 1'b1 : sh_q[0];
            sh_q   <= {1'b1, sh_q[10:1]};
         end else begin
            cyc_q <= cyc_q - 16'd1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/uls_top.sv
// line status block of a serial port with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
module uls_top
   import uls_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         sys_rst,
   // axi4-lite write address and data
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   // axi4-lite write response
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   // serial line
   input  wire logic         rxd,
   output logic              txd,
   // interrupt requests
   output logic              tx_empty_irq,
   output logic              rx_status_irq
);
   // ---------------------------------------------------------------
   // control register and line synchroniser
   // ---------------------------------------------------------------
   logic [7:0]  ctrl_q;
   logic        rxd_s1_q;
   logic        rxd_s2_q;
   uls_frame_t  frame;
   logic        fifo_mode;

   assign fifo_mode  = ctrl_q[ULS_C_FIFO];
   assign frame.en   = ctrl_q[ULS_C_PEN];
   assign frame.sel  = ctrl_q[ULS_C_PSEL +: 2];
   assign frame.wlen = ctrl_q[ULS_C_WLEN +: 2];

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rxd_s1_q <= 1'b1;
         rxd_s2_q <= 1'b1;
      end else begin
         rxd_s1_q <= rxd;
         rxd_s2_q <= rxd_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite slave
   // ---------------------------------------------------------------
   logic        aw_q;
   logic        w_q;
   logic [7:0]  awaddr_q;
   logic [7:0]  wdata_q;
   logic        wstb_q;
   logic        wr_go;
   logic        rd_go;
   logic        lsr_rd;
   logic        rbr_rd;
   logic        thr_wr;
   logic        ctl_wr;
   logic [7:0]  line_status;

   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go  = aw_q && w_q && !s_axi_bvalid;
   assign rd_go  = s_axi_arvalid && s_axi_arready;
   assign lsr_rd = rd_go &&
                   s_axi_araddr[7:2] == ULS_LINE_STATUS_ADDR[7:2];
   assign rbr_rd = rd_go && s_axi_araddr[7:2] == ULS_RX_DATA_ADDR[7:2];
   assign thr_wr = wr_go && wstb_q && awaddr_q[7:2] == ULS_TX_DATA_ADDR[7:2];
   assign ctl_wr = wr_go && wstb_q && awaddr_q[7:2] == ULS_CONTROL_ADDR[7:2];

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         aw_q         <= 1'b0;
         w_q          <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 8'h00;
         wstb_q       <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wstb_q  <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // status word is read-only: writes to it are dropped
            s_axi_bresp  <= (awaddr_q[7:2] == ULS_TX_DATA_ADDR[7:2] ||
                             awaddr_q[7:2] == ULS_CONTROL_ADDR[7:2])
                            ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         ctrl_q <= ULS_CONTROL_RST;
      else if (ctl_wr)
         ctrl_q <= wdata_q;
   end

   // ---------------------------------------------------------------
   // receive path: buffer (depth 1) or fifo (depth 16)
   // ---------------------------------------------------------------
   uls_rxchar_t rx_char;
   logic        rx_vld;
   uls_rxchar_t mem_q [ULS_FIFO_DEPTH];
   logic [ULS_FIFO_AW-1:0] wp_q;
   logic [ULS_FIFO_AW-1:0] rp_q;
   logic [ULS_FIFO_AW:0]   cnt_q;
   logic        depth_full;
   logic        rx_push;
   logic        rx_pop;
   uls_rxchar_t head;

   uls_rx u_rx (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .rxd_sync (rxd_s2_q),
      .frame    (frame),
      .char_vld (rx_vld),
      .char_q   (rx_char)
   );

   assign head       = mem_q[rp_q];
   assign depth_full = fifo_mode ? (cnt_q == (ULS_FIFO_AW+1)'(ULS_FIFO_DEPTH))
                                 : (cnt_q != '0);
   // fifo full: the new char stays in the shifter and is lost
   assign rx_push = rx_vld && (!depth_full || !fifo_mode);
   assign rx_pop  = rbr_rd && cnt_q != '0;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else if (ctl_wr && wdata_q[ULS_C_FIFO] != fifo_mode) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         // character mode overwrites the single held slot
         if (rx_vld && !fifo_mode && cnt_q != '0 && !rx_pop) begin
            mem_q[rp_q] <= rx_char;
         end else if (rx_push) begin
            mem_q[wp_q] <= rx_char;
            wp_q <= fifo_mode ? wp_q + 1'b1 : wp_q;
         end
         if (rx_pop && fifo_mode)
            rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (ULS_FIFO_AW+1)'(rx_push && !(rx_vld && !fifo_mode
                  && cnt_q != '0 && !rx_pop)) - (ULS_FIFO_AW+1)'(rx_pop);
      end
   end

   // ---------------------------------------------------------------
   // sticky flags, cleared by a host read of line status
   // ---------------------------------------------------------------
   logic oe_q;
   logic pe_q;
   logic fe_q;
   logic bi_q;
   logic errf_q;
   logic head_new;
   logic any_err;
   logic prev_cnt_zero_q;

   // a character reaches the head on push into empty or on a pop with two or more held
   assign head_new = (rx_push && cnt_q == '0) || (rx_pop && cnt_q > 1);
   assign any_err  = (rx_push && (rx_char.par | rx_char.frm | rx_char.brk));

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         oe_q   <= 1'b0;
         pe_q   <= 1'b0;
         fe_q   <= 1'b0;
         bi_q   <= 1'b0;
         errf_q <= 1'b0;
         prev_cnt_zero_q <= 1'b1;
      end else begin
         prev_cnt_zero_q <= (cnt_q == '0);
         // set wins over a clear in the same cycle
         if (lsr_rd) begin
            oe_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
            bi_q <= 1'b0;
         end
         if (rx_vld && depth_full && (fifo_mode || !rx_pop))
            oe_q <= 1'b1;
         if (!fifo_mode && rx_vld) begin
            if (rx_char.par) pe_q <= 1'b1;
            if (rx_char.frm) fe_q <= 1'b1;
            if (rx_char.brk) bi_q <= 1'b1;
         end else if (fifo_mode && head_new) begin
            if (rx_push && cnt_q == '0) begin
               if (rx_char.par) pe_q <= 1'b1;
               if (rx_char.frm) fe_q <= 1'b1;
               if (rx_char.brk) bi_q <= 1'b1;
            end else begin
               if (mem_q[rp_q + 1'b1].par) pe_q <= 1'b1;
               if (mem_q[rp_q + 1'b1].frm) fe_q <= 1'b1;
               if (mem_q[rp_q + 1'b1].brk) bi_q <= 1'b1;
            end
         end
         if (lsr_rd && fifo_mode)
            errf_q <= 1'b0;
         if (fifo_mode && any_err)
            errf_q <= 1'b1;
         if (!fifo_mode)
            errf_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // transmit path: holding register (depth 1) or fifo (depth 16)
   // ---------------------------------------------------------------
   logic [7:0]  tmem_q [ULS_FIFO_DEPTH];
   logic [ULS_FIFO_AW-1:0] twp_q;
   logic [ULS_FIFO_AW-1:0] trp_q;
   logic [ULS_FIFO_AW:0]   tcnt_q;
   logic        tx_busy;
   logic        tx_load;
   logic        tx_take;
   logic        tx_room;
   logic        thre_q;

   assign tx_room = fifo_mode ? (tcnt_q != (ULS_FIFO_AW+1)'(ULS_FIFO_DEPTH))
                              : (tcnt_q == '0);
   assign tx_take = thr_wr && tx_room;
   assign tx_load = !tx_busy && tcnt_q != '0;

   uls_tx u_tx (
      .clock   (clock),
      .sys_rst (sys_rst),
      .load    (tx_load),
      .data    (tmem_q[trp_q]),
      .frame   (frame),
      .busy    (tx_busy),
      .txd     (txd)
   );

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         twp_q  <= '0;
         trp_q  <= '0;
         tcnt_q <= '0;
      end else begin
         if (tx_take) begin
            tmem_q[twp_q] <= wdata_q;
            twp_q <= twp_q + 1'b1;
         end
         if (tx_load)
            trp_q <= trp_q + 1'b1;
         tcnt_q <= tcnt_q + (ULS_FIFO_AW+1)'(tx_take)
                          - (ULS_FIFO_AW+1)'(tx_load);
      end
   end

   // holding empty: set when the last queued char is handed off, cleared on host write
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         thre_q <= 1'b1;
      else if (tx_take)
         thre_q <= 1'b0;
      else if (tcnt_q == '0 || (tx_load && tcnt_q == 1))
         thre_q <= 1'b1;
   end

   // ---------------------------------------------------------------
   // status word, read data and interrupts
   // ---------------------------------------------------------------
   always_comb begin
      line_status             = '0;
      line_status[ULS_B_DR]   = cnt_q != '0;
      line_status[ULS_B_OE]   = oe_q;
      line_status[ULS_B_PE]   = pe_q;
      line_status[ULS_B_FE]   = fe_q;
      line_status[ULS_B_BI]   = bi_q;
      line_status[ULS_B_THRE] = thre_q;
      line_status[ULS_B_TEMT] = thre_q && tcnt_q == '0 && !tx_busy;
      line_status[ULS_B_ERRF] = errf_q && fifo_mode;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         s_axi_rdata  <= 32'h0000_0000;
         if (lsr_rd)
            s_axi_rdata[7:0] <= line_status;
         else if (rbr_rd)
            s_axi_rdata[7:0] <= (cnt_q != '0) ? head.data : 8'h00;
         else if (s_axi_araddr[7:2] == ULS_CONTROL_ADDR[7:2])
            s_axi_rdata[7:0] <= ctrl_q;
         else
            s_axi_rresp <= 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   logic thre_prev_q;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         thre_prev_q  <= 1'b1;
         tx_empty_irq <= 1'b0;
      end else begin
         thre_prev_q <= thre_q;
         if (!ctrl_q[ULS_C_ITX] || tx_take)
            tx_empty_irq <= 1'b0;
         else if (thre_q && !thre_prev_q)
            tx_empty_irq <= 1'b1;
      end
   end

   assign rx_status_irq = ctrl_q[ULS_C_IRX] &&
                          (oe_q | pe_q | fe_q | bi_q);
endmodule
`default_nettype wire

// ===== sim/uls_monitor.sv
// bus and status checker bound to the line status block
`timescale 1ns/1ps
`default_nettype none
module uls_monitor
   import uls_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        sys_rst,
   // register bus
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // interrupt
   input wire logic        rx_status_irq
);
   wire  ar = s_axi_arvalid && s_axi_arready;
   wire  aw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire  ok = s_axi_araddr[7:2] inside {ULS_RX_DATA_ADDR[7:2],
              ULS_LINE_STATUS_ADDR[7:2], ULS_CONTROL_ADDR[7:2]};
   wire  st_rd = s_axi_araddr == ULS_LINE_STATUS_ADDR;
   wire  st_wr = s_axi_awaddr == ULS_LINE_STATUS_ADDR;
   logic st_q;
   // remembers whether the pending read targets line status
   always_ff @(posedge clock or posedge sys_rst)
      if (sys_rst) st_q <= 1'b0;
      else if (ar) st_q <= st_rd;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   st_read_a: assert property (ar && st_rd
      |=> s_axi_rvalid && s_axi_rresp == 2'b00 && s_axi_rdata[31:8] == 0)
      else $error("status read answer wrong");
   st_write_a: assert property (aw && st_wr
      |=> ##1 s_axi_bvalid && s_axi_bresp == 2'b10) else $error("status write");
   bad_read_a: assert property (ar && !ok
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 0) else $error("unmapped read");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   irq_clear_a: assert property ($rose(s_axi_rvalid) && st_q
      |-> !rx_status_irq) else $error("status read kept irq");
   temt_thre_a: assert property ($rose(s_axi_rvalid) && st_q
      && s_axi_rdata[6] |-> s_axi_rdata[5]) else $error("empty bits disagree");
   wr_resp_a: assert property (aw |=> ##1 s_axi_bvalid) else $error("late write");
endmodule
`default_nettype wire

// ===== sim/uls_line_model.sv
// remote serial device: sends framed characters, captures sent ones
`timescale 1ns/1ps
`default_nettype none
module uls_line_model
   import uls_pkg::*;
(
   // clock
   input  wire logic clock,
   // serial line
   output logic      rxd,
   input  wire logic txd
);
   logic [9:0] sh;
   initial rxd = 1'b1;
   // start, 8 data lsb first, parity, stop; n bits forced low for break
   task automatic send(input logic [7:0] d, input logic p, input logic s,
                       input int n);
      logic [12:0] f;
      f = {2'b11, s, p, d, 1'b0};
      for (int i = 0; i < 13; i++) begin
         @(posedge clock) rxd <= (i < n) ? 1'b0 : f[i];
         repeat (ULS_BIT_CYC - 1) @(posedge clock);
      end
      // a break must not leave the line stuck low for the next frame
      rxd <= 1'b1;
   endtask
   // samples mid-bit, 10 bits after the start edge
   initial forever begin
      @(negedge txd);
      repeat (ULS_BIT_CYC / 2) @(posedge clock);
      for (int i = 0; i < 10; i++) begin
         repeat (ULS_BIT_CYC) @(posedge clock);
         sh = {txd, sh[9:1]};
      end
   end
endmodule
`default_nettype wire

// ===== sim/uls_line_status_test.sv
// self-checking bench for the line status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module uls_line_status_test
   import uls_pkg::*;
;
   logic        clock = 0, sys_rst = 1, rxd, txd, tx_empty_irq, rx_status_irq;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   int          fails = 0, checks = 0;
   uls_top dut (.*);
   uls_line_model line (.clock, .rxd, .txd);
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      {s_axi_awaddr, s_axi_wdata} <= {a, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic ck(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {r, d} = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'b0;
      `CHK(d, {24'h00_0000, e})
   endtask
   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial forever #50 clock = ~clock;
   initial begin
      repeat (60000) @(posedge clock);
      fails++;
      test_done;
   end
   initial begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      ck(ULS_LINE_STATUS_ADDR, 8'h60);
      wr(ULS_LINE_STATUS_ADDR, 32'h0000_00ff);
      `CHK(r, 2'b10)
      ck(8'h10, 8'h00);
      `CHK(r, 2'b10)
      ck(ULS_LINE_STATUS_ADDR, 8'h60);
      $display("test bus done");
      // character mode, 8 data bits, even parity, both irqs enabled
      wr(ULS_CONTROL_ADDR, 32'h0000_00f6);
      line.send(8'ha5, 1'b1, 1'b1, 0);
      `CHK(rx_status_irq, 1'b1)
      ck(ULS_LINE_STATUS_ADDR, 8'h65);
      line.send(8'ha5, 1'b1, 1'b1, 0);
      ck(ULS_RX_DATA_ADDR, 8'ha5);
      ck(ULS_LINE_STATUS_ADDR, 8'h66);
      ck(ULS_LINE_STATUS_ADDR, 8'h60);
      line.send(8'h3c, 1'b0, 1'b1, 0);
      line.send(8'h81, 1'b0, 1'b1, 0);
      ck(ULS_LINE_STATUS_ADDR, 8'h63);
      ck(ULS_RX_DATA_ADDR, 8'h81);
      line.send(8'h0f, 1'b0, 1'b0, 0);
      ck(ULS_LINE_STATUS_ADDR, 8'h69);
      ck(ULS_RX_DATA_ADDR, 8'h0f);
      // the break character overwrites the unread framed zero
      line.send(8'h00, 1'b0, 1'b0, 13);
      ck(ULS_LINE_STATUS_ADDR, 8'h7b);
      $display("test receive done");
      wr(ULS_CONTROL_ADDR, 32'h0000_00f7);
      line.send(8'ha5, 1'b1, 1'b1, 0);
      ck(ULS_LINE_STATUS_ADDR, 8'he5);
      ck(ULS_LINE_STATUS_ADDR, 8'h61);
      ck(ULS_RX_DATA_ADDR, 8'ha5);
      wr(ULS_TX_DATA_ADDR, 32'h0000_005a);
      ck(ULS_LINE_STATUS_ADDR, 8'h20);
      `CHK(d[6], 1'b0)
      repeat (12 * ULS_BIT_CYC) @(posedge clock);
      `CHK(line.sh, 10'h25a)
      `CHK(tx_empty_irq, 1'b1)
      ck(ULS_LINE_STATUS_ADDR, 8'h60);
      $display("test transmit done");
      test_done;
   end
endmodule
bind uls_top uls_monitor mon (.*);
`default_nettype wire
